// ===== rtl/msg_word_pkg.sv
// Function
// - Word two bit 9 flags remote request
// - Remote flag ignored in standard format
// - Filler writes zero to bits 8, 4
// - Word two bits 7-5 read zero
// - Length code in word two bits 3-0
// - Word three upper byte is payload byte1
// - Word three lower byte is payload byte0
// - Buffers live in shared message RAM
package msg_word_pkg;
   localparam int WORD_W = 16;
   localparam int EID_HI = 15;
   localparam int EID_LO = 10;
   localparam int RTR_BIT = 9;
   localparam int RSV_UP_BIT = 8;
   localparam int UNIMP_HI = 7;
   localparam int UNIMP_LO = 5;
   localparam int RSV_LO_BIT = 4;
   localparam int DLC_HI = 3;
   localparam int DLC_LO = 0;
   localparam int BYTE1_HI = 15;
   localparam int BYTE1_LO = 8;
   localparam int BYTE0_HI = 7;
   localparam int BYTE0_LO = 0;
   localparam logic [15:0] WORD_TWO_RD_MASK = 16'hFF1F;
   localparam logic [15:0] WORD_TWO_WR_MASK = 16'hFF1F;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [0:0] SEL_WORD_TWO = 1'h0;
   localparam logic [0:0] SEL_WORD_THREE = 1'h1;
endpackage

// ===== rtl/msg_word_if.sv
`timescale 1ns/1ps
`default_nettype none
// Word access port between buffer RAM owner and protocol engine
interface msg_word_if;
   logic wr_en;
   logic rd_en;
   logic word_sel;
   logic [15:0] wr_data;
   logic [15:0] rd_data;
   logic rd_valid;
   modport buffer (input wr_en, rd_en, word_sel, wr_data, output rd_data, rd_valid);
   modport engine (output wr_en, rd_en, word_sel, wr_data, input rd_data, rd_valid);
endinterface
`default_nettype wire

// ===== rtl/msg_word_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module msg_word_buffer
   import msg_word_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RESETN,
   msg_word_if.buffer LINK,
   input wire logic SW_WR_EN,
   input wire logic SW_WORD_SEL,
   input wire logic [15:0] SW_WR_DATA,
   input wire logic SW_RD_EN,
   output logic [15:0] SW_RD_DATA,
   output logic SW_RD_VALID
);
   // Contents unknown at power up; words held in registers that have no reset
   logic [15:0] word_two_q;
   logic [15:0] word_three_q;
   logic [15:0] link_rd_q;
   logic link_vld_q;
   logic [15:0] sw_rd_q;
   logic sw_vld_q;
   logic wr2, wr3;
   logic [15:0] wdata;

   ////////////////////////////////////////////////////////////////////
   // Software write has priority over engine write in the same cycle
   always_comb begin
      wr2 = 1'b0;
      wr3 = 1'b0;
      wdata = SW_WR_DATA;
      if (SW_WR_EN) begin
         wr2 = (SW_WORD_SEL == SEL_WORD_TWO);
         wr3 = (SW_WORD_SEL == SEL_WORD_THREE);
      end else if (LINK.wr_en) begin
         wdata = LINK.wr_data;
         wr2 = (LINK.word_sel == SEL_WORD_TWO);
         wr3 = (LINK.word_sel == SEL_WORD_THREE);
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (wr2) begin
         // Unimplemented bits 7-5 not stored
         word_two_q <= wdata & WORD_TWO_WR_MASK;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (wr3) begin
         word_three_q <= wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         link_vld_q <= 1'b0;
         link_rd_q <= WORD_ZERO;
      end else begin
         link_vld_q <= LINK.rd_en;
         if (LINK.rd_en) begin
            link_rd_q <= (LINK.word_sel == SEL_WORD_TWO) ?
               (word_two_q & WORD_TWO_RD_MASK) : word_three_q;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         sw_vld_q <= 1'b0;
         sw_rd_q <= WORD_ZERO;
      end else begin
         sw_vld_q <= SW_RD_EN;
         if (SW_RD_EN) begin
            sw_rd_q <= (SW_WORD_SEL == SEL_WORD_TWO) ?
               (word_two_q & WORD_TWO_RD_MASK) : word_three_q;
         end
      end
   end

   assign LINK.rd_data = link_rd_q;
   assign LINK.rd_valid = link_vld_q;
   assign SW_RD_DATA = sw_rd_q;
   assign SW_RD_VALID = sw_vld_q;
endmodule
`default_nettype wire

// ===== rtl/msg_word_engine.sv
`timescale 1ns/1ps
`default_nettype none
module msg_word_engine
   import msg_word_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RESETN,
   msg_word_if.engine LINK,
   input wire logic FETCH,
   input wire logic STORE,
   input wire logic IDE,
   input wire logic RX_RTR,
   input wire logic [5:0] RX_EXT_IDENT_LOW_SIX,
   input wire logic [3:0] RX_DLC,
   input wire logic [7:0] RX_BYTE0,
   input wire logic [7:0] RX_BYTE1,
   output logic BUSY,
   output logic DONE,
   output logic FRAME_RTR,
   output logic [5:0] EXT_IDENT_LOW_SIX,
   output logic [3:0] FRAME_DLC,
   output logic [7:0] FRAME_BYTE0,
   output logic [7:0] FRAME_BYTE1
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_RD2 = 3'h1, ST_RD3 = 3'h3, ST_WAIT3 = 3'h2,
      ST_WR2 = 3'h6, ST_WR3 = 3'h7
   } state_t;
   state_t state_q;
   logic rtr_q;
   logic [5:0] eid_q;
   logic [3:0] dlc_q;
   logic [7:0] b0_q, b1_q;
   logic done_q;
   logic [15:0] word2_out;

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      word2_out = WORD_ZERO;
      word2_out[EID_HI:EID_LO] = RX_EXT_IDENT_LOW_SIX;
      word2_out[RTR_BIT] = IDE & RX_RTR;
      word2_out[RSV_UP_BIT] = 1'b0;
      word2_out[RSV_LO_BIT] = 1'b0;
      word2_out[DLC_HI:DLC_LO] = RX_DLC;
   end

   always_comb begin
      LINK.wr_en = (state_q == ST_WR2) || (state_q == ST_WR3);
      LINK.rd_en = (state_q == ST_RD2) || (state_q == ST_RD3);
      LINK.word_sel = ((state_q == ST_RD3) || (state_q == ST_WR3)) ?
         SEL_WORD_THREE : SEL_WORD_TWO;
      LINK.wr_data = (state_q == ST_WR3) ? {RX_BYTE1, RX_BYTE0} : word2_out;
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (FETCH) begin
                  state_q <= ST_RD2;
               end else if (STORE) begin
                  state_q <= ST_WR2;
               end
            end
            ST_RD2: state_q <= ST_RD3;
            ST_RD3: state_q <= ST_WAIT3;
            ST_WAIT3: state_q <= ST_IDLE;
            ST_WR2: state_q <= ST_WR3;
            ST_WR3: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         rtr_q <= 1'b0;
         eid_q <= 6'h00;
         dlc_q <= 4'h0;
         b0_q <= 8'h00;
         b1_q <= 8'h00;
      end else if (LINK.rd_valid) begin
         if (state_q == ST_RD3) begin
            eid_q <= LINK.rd_data[EID_HI:EID_LO];
            rtr_q <= IDE & LINK.rd_data[RTR_BIT];
            dlc_q <= LINK.rd_data[DLC_HI:DLC_LO];
         end else begin
            b1_q <= LINK.rd_data[BYTE1_HI:BYTE1_LO];
            b0_q <= LINK.rd_data[BYTE0_HI:BYTE0_LO];
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         done_q <= 1'b0;
      end else begin
         done_q <= (state_q == ST_WAIT3) || (state_q == ST_WR3);
      end
   end

   assign BUSY = (state_q != ST_IDLE);
   assign DONE = done_q;
   assign FRAME_RTR = rtr_q;
   assign EXT_IDENT_LOW_SIX = eid_q;
   assign FRAME_DLC = dlc_q;
   assign FRAME_BYTE0 = b0_q;
   assign FRAME_BYTE1 = b1_q;
endmodule
`default_nettype wire

// ===== tb/msg_word_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module msg_word_monitor (
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic word_sel,
   input wire logic [15:0] wr_data,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid
);
   default clocking mon_cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   a_read_answer_next: assert property (rd_en |=> rd_valid)
      else $error("read not answered");
   a_no_stray_valid: assert property (!rd_en |=> !rd_valid)
      else $error("stray read valid");
   a_data_holds_idle: assert property (!rd_valid |-> $stable(rd_data))
      else $error("read data moved");
   a_unimp_read_zero: assert property (rd_valid && !$past(word_sel) |-> rd_data[7:5] == 3'h0)
      else $error("unused bits not zero");
   a_reserved_write_zero: assert property (wr_en && !word_sel |-> !wr_data[8] && !wr_data[4])
      else $error("reserved bit written high");
   a_store_word_order: assert property (wr_en && !word_sel |=> wr_en && word_sel)
      else $error("payload word not stored next");
   a_fetch_word_order: assert property (rd_en && !word_sel |=> rd_en && word_sel)
      else $error("payload word not fetched next");
   a_single_strobe: assert property (!(wr_en && rd_en))
      else $error("read and write together");
endmodule
`default_nettype wire

// ===== tb/can_msg_buffer_word_format_tb.sv
`timescale 1ns/1ps
`default_nettype none
module can_msg_buffer_word_format_tb;
   import msg_word_pkg::*;
   logic clk = 1'h0, rstn = 1'h0, sw_wr = 1'h0, sw_sel = 1'h0, sw_rd = 1'h0, sw_v;
   logic fetch = 1'h0, store = 1'h0, ide = 1'h0, rtr = 1'h0, busy, done, f_rtr;
   logic [15:0] sw_data = 16'h0000, sw_q;
   logic [5:0] eid = 6'h00, f_eid;
   logic [3:0] dlc = 4'h0, f_dlc;
   logic [7:0] b0 = 8'h00, b1 = 8'h00, f_b0, f_b1;
   int err_total = 0, samples_checked = 0, cycles = 0;
   always #25 clk = ~clk;
   msg_word_if link ();
   msg_word_buffer u_msg_word_buffer (.SYS_CLK(clk), .RESETN(rstn), .LINK(link.buffer),
      .SW_WR_EN(sw_wr), .SW_WORD_SEL(sw_sel), .SW_WR_DATA(sw_data), .SW_RD_EN(sw_rd),
      .SW_RD_DATA(sw_q), .SW_RD_VALID(sw_v));
   msg_word_engine u_msg_word_engine (.SYS_CLK(clk), .RESETN(rstn), .LINK(link.engine),
      .FETCH(fetch), .STORE(store), .IDE(ide), .RX_RTR(rtr), .RX_EXT_IDENT_LOW_SIX(eid),
      .RX_DLC(dlc), .RX_BYTE0(b0), .RX_BYTE1(b1), .BUSY(busy), .DONE(done),
      .FRAME_RTR(f_rtr), .EXT_IDENT_LOW_SIX(f_eid), .FRAME_DLC(f_dlc),
      .FRAME_BYTE0(f_b0), .FRAME_BYTE1(f_b1));
   msg_word_monitor u_msg_word_monitor (.SYS_CLK(clk), .RESETN(rstn), .wr_en(link.wr_en),
      .rd_en(link.rd_en), .word_sel(link.word_sel), .wr_data(link.wr_data),
      .rd_data(link.rd_data), .rd_valid(link.rd_valid));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic sw_write(input logic sel, input logic [15:0] d);
      sw_wr = 1'h1;
      sw_sel = sel;
      sw_data = d;
      @(posedge clk) #1;
      sw_wr = 1'h0;
      @(posedge clk) #1;
   endtask
   task automatic sw_check(input logic sel, input logic [15:0] exp);
      sw_rd = 1'h1;
      sw_sel = sel;
      @(posedge clk) #1;
      sw_rd = 1'h0;
      chk("sw valid", {15'h0000, sw_v}, 16'h0001);
      chk("sw word", sw_q, exp);
      @(posedge clk) #1;
   endtask
   // Engine request, then count cycles up to its completion pulse
   task automatic run(input logic is_fetch);
      int n = 0;
      fetch = is_fetch;
      store = ~is_fetch;
      @(posedge clk) #1;
      fetch = 1'h0;
      store = 1'h0;
      chk("busy raised", {15'h0000, busy}, 16'h0001);
      while (done !== 1'h1 && n < 20) begin
         @(posedge clk) #1;
         n++;
      end
      chk("done latency", 16'(n), is_fetch ? 16'h0003 : 16'h0002);
      chk("busy cleared", {15'h0000, busy}, 16'h0000);
      @(posedge clk) #1;
      chk("done pulse", {15'h0000, done}, 16'h0000);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_fetch(input logic ide_v);
      sw_write(SEL_WORD_TWO, 16'hAEE8);
      sw_write(SEL_WORD_THREE, 16'h5AC3);
      ide = ide_v;
      run(1'h1);
      chk("remote flag", {15'h0000, f_rtr}, {15'h0000, ide_v});
      chk("ident low", {10'h000, f_eid}, 16'h002B);
      chk("length", {12'h000, f_dlc}, 16'h0008);
      chk("payload", {f_b1, f_b0}, 16'h5AC3);
   endtask
   task automatic t_store(input logic ide_v);
      ide = ide_v;
      rtr = 1'h1;
      eid = 6'h15;
      dlc = 4'h3;
      b0 = 8'h96;
      b1 = 8'h69;
      run(1'h0);
      sw_check(SEL_WORD_TWO, {6'h15, ide_v, 9'h003});
      sw_check(SEL_WORD_THREE, 16'h6996);
   endtask
   task automatic t_reset();
      chk("busy after reset", {15'h0000, busy}, 16'h0000);
      chk("done after reset", {15'h0000, done}, 16'h0000);
      chk("sw valid after reset", {15'h0000, sw_v}, 16'h0000);
      chk("sw word after reset", sw_q, 16'h0000);
      chk("payload after reset", {f_b1, f_b0}, 16'h0000);
      chk("fields after reset", {5'h00, f_rtr, f_eid, f_dlc}, 16'h0000);
   endtask
   // Bits 8 and 4 are kept, bits 7-5 read back as zero
   task automatic t_unimp();
      sw_write(SEL_WORD_TWO, 16'hA7F5);
      sw_check(SEL_WORD_TWO, 16'hA715);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      #1 rstn = 1'h1;
      t_reset();
      t_unimp();
      t_fetch(1'h1);
      t_fetch(1'h0);
      t_store(1'h1);
      t_store(1'h0);
      conclude();
   end
endmodule
`default_nettype wire
